// [rtl/period_timer_pkg.sv]
// Purpose: shared constants and carriers of the period match timer block
// Assumes: 32-bit AHB-Lite register bus, one system clock
// Notes: offsets are byte offsets inside the block's window
//
// Overview of operation
// RULE1: each timer has an 8-bit count and an 8-bit period, and every register is read/write; here the flag register is write one to clear.
// RULE2: the count clock is the system clock divided by four, then prescaled by 1, 4 or 16.
// RULE3: a match event fires when the count equals the period, the only interrupt source.
// RULE4: matches pass a 4-bit postscaler (1:1 to 1:16) whose completion sets the sticky flag.
// RULE5: the run bit at control bit 2 stops the timer when low and lets it count when high.
// RULE6: every reset clears the count.
// RULE7: count writes, control writes and resets clear the prescaler and postscaler.
// RULE8: a control write leaves the count as it was.
// RULE9: the flags of timers one to five sit at bits 0, 2, 4, 5 and 6 of the flag register.
// RULE10: each timer's enable bit sits at its flag's position and masks its interrupt.
// RULE11: each raw match is driven out as a pwm period time base.
// RULE12: the number of timers is a build parameter (five, or three on small parts).
// RULE13: the prescaled tick after a match loads zero, so the period is value plus one.
package period_timer_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned CH_STRIDE = 16;
  localparam logic [7:0] OFS_COUNT = 8'h00;
  localparam logic [7:0] OFS_PERIOD = 8'h04;
  localparam logic [7:0] OFS_CONTROL = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h60;
  localparam logic [7:0] OFS_ENABLE = 8'h64;

  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int unsigned CTL_DIV_LSB = 0;
  localparam int unsigned CTL_RUN_BIT = 2;
  localparam int unsigned CTL_POST_LSB = 3;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'hff;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam int unsigned MAX_TIMERS = 5;
  localparam int unsigned FLAG_POS [0:4] = '{0, 2, 4, 5, 6};

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned INSTR_DIV = 4;
  localparam logic [3:0] PRE_LIM_1 = 4'h0;
  localparam logic [3:0] PRE_LIM_4 = 4'h3;
  localparam logic [3:0] PRE_LIM_16 = 4'hf;

  typedef enum logic [1:0] {
    DIV_1 = 2'b00,
    DIV_4 = 2'b01,
    DIV_16 = 2'b10,
    DIV_16B = 2'b11
  } div_sel_e;

  // write strobes towards one timer
  typedef struct packed {
    logic wr_count;
    logic wr_period;
    logic wr_control;
    logic [7:0] wdata;
  } chan_wr_s;

  // what one timer shows
  typedef struct packed {
    logic [7:0] count;
    logic [7:0] period;
    logic [7:0] control;
    logic match;
    logic post_event;
  } chan_stat_s;

endpackage

// [rtl/instr_tick_gen.sv]
// Purpose: one-cycle tick at the instruction rate, system clock over four
// Assumes: free running from reset release
// Notes: tick is a registered pulse
`timescale 1ns/1ps
`default_nettype none
module instr_tick_gen (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  output logic tick_o
);
  import period_timer_pkg::*;

  typedef struct packed {
    logic [1:0] cnt;
    logic tick;
  } tick_state_s;

  tick_state_s s_q, s_d;

  // divide by four
  always_comb begin
    s_d = s_q;
    s_d.cnt = s_q.cnt + 2'd1;
    s_d.tick = (s_q.cnt == 2'(INSTR_DIV - 1)); // [RULE2]
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_o = s_q.tick;

  AST_TICK_SPACING: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    s_q.tick |=> !s_q.tick [*3] ##1 s_q.tick) // [RULE2]
    else $error("instruction tick not every fourth cycle");
endmodule
`default_nettype wire

// [rtl/timer_channel.sv]
// Purpose: one 8-bit period timer with prescaler and postscaler
// Assumes: writes arrive as one-cycle strobes
// Notes: a count write wins over a count tick in the same cycle; a control write lets the tick advance the count
`timescale 1ns/1ps
`default_nettype none
module timer_channel (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic instr_tick_i,
  input wire period_timer_pkg::chan_wr_s wr_i,
  output period_timer_pkg::chan_stat_s stat_o
);
  import period_timer_pkg::*;

  typedef struct packed {
    logic [7:0] count;
    logic [7:0] period;
    logic [7:0] control;
    logic [3:0] pre_cnt;
    logic [3:0] post_cnt;
    logic match;
    logic post_event;
  } chan_state_s;

  chan_state_s s_q, s_d;
  logic run;
  logic [3:0] pre_lim;
  logic cnt_tick;

  // prescale limit and tick
  assign run = s_q.control[CTL_RUN_BIT]; // [RULE5]
  always_comb begin
    case (div_sel_e'(s_q.control[CTL_DIV_LSB +: 2]))
      DIV_1: pre_lim = PRE_LIM_1;
      DIV_4: pre_lim = PRE_LIM_4;
      default: pre_lim = PRE_LIM_16;
    endcase
  end
  assign cnt_tick = run && instr_tick_i && (s_q.pre_cnt == pre_lim); // [RULE2]

  // next state
  always_comb begin
    s_d = s_q;
    s_d.match = 1'b0;
    s_d.post_event = 1'b0;
    if (run && instr_tick_i) begin
      s_d.pre_cnt = cnt_tick ? 4'h0 : s_q.pre_cnt + 4'h1; // [RULE2]
    end
    if (cnt_tick) begin
      if (s_q.count == s_q.period) begin
        s_d.count = 8'h00; // [RULE13]
        s_d.match = 1'b1; // [RULE3]
        if (s_q.post_cnt == s_q.control[CTL_POST_LSB +: 4]) begin
          s_d.post_cnt = 4'h0;
          s_d.post_event = 1'b1; // [RULE4]
        end else begin
          s_d.post_cnt = s_q.post_cnt + 4'h1;
        end
      end else begin
        s_d.count = s_q.count + 8'h01;
      end
    end
    if (wr_i.wr_period) begin
      s_d.period = wr_i.wdata; // [RULE1]
    end
    if (wr_i.wr_count) begin
      s_d.count = wr_i.wdata; // [RULE1]
      s_d.pre_cnt = 4'h0; // [RULE7]
      s_d.post_cnt = 4'h0;
    end
    if (wr_i.wr_control) begin
      s_d.control = wr_i.wdata; // count kept [RULE8]
      s_d.pre_cnt = 4'h0; // [RULE7]
      s_d.post_cnt = 4'h0;
    end
  end

  // state register, reset clears count and scalers
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '{count: COUNT_RST, period: PERIOD_RST, control: CONTROL_RST,
               default: '0}; // [RULE6] [RULE7]
    end else begin
      s_q <= s_d;
    end
  end

  assign stat_o = '{count: s_q.count, period: s_q.period, control: s_q.control,
                    match: s_q.match, post_event: s_q.post_event}; // [RULE11]

  AST_WRAP_ZERO: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    cnt_tick && s_q.count == s_q.period && !wr_i.wr_count |=> s_q.count == 8'h00 && s_q.match) // [RULE13]
    else $error("count did not wrap to zero after match");
  AST_CTL_KEEPS: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    wr_i.wr_control && !wr_i.wr_count && !cnt_tick |=> s_q.count == $past(s_q.count)) // [RULE8]
    else $error("control write changed the count");
  AST_SCALER_CLR: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    wr_i.wr_count || wr_i.wr_control |=> s_q.pre_cnt == 4'h0 && s_q.post_cnt == 4'h0) // [RULE7]
    else $error("scalers not cleared by write");
  AST_STOPPED: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !run && !wr_i.wr_count |=> s_q.count == $past(s_q.count) && !s_q.match) // [RULE5]
    else $error("stopped timer moved");
  AST_POST_ON_MATCH: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    s_q.post_event |-> s_q.match) // [RULE4]
    else $error("postscaler event without match");
  AST_MATCH_CAUSE: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    s_q.match |-> $past(cnt_tick) && $past(s_q.count) == $past(s_q.period)) // [RULE3]
    else $error("match without equal count");
  AST_PRE16: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    cnt_tick && pre_lim == PRE_LIM_16 && !wr_i.wr_count && !wr_i.wr_control
    ##1 (!wr_i.wr_count && !wr_i.wr_control) [*8] |-> !cnt_tick) // [RULE2]
    else $error("prescale 16 ticked too early");
  CVR_POSTSCALE: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    s_q.post_event && s_q.control[CTL_POST_LSB +: 4] != 4'h0);
endmodule
`default_nettype wire

// [rtl/period_timer_top.sv]
// Purpose: AHB-Lite slave holding a group of 8-bit period match timers
// Assumes: single word transfers; OKAY always
// Notes: reads take one wait state, writes none
//
// Design decisions made here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module period_timer_top #(
  parameter int unsigned NUM_TIMERS = period_timer_pkg::MAX_TIMERS
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  output logic irq_o,
  output logic [NUM_TIMERS-1:0] pwm_time_base_o
);
  import period_timer_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic ph_valid;
    logic ph_write;
    logic rd_wait;
    logic [ADDR_W-1:0] ph_addr;
    logic [31:0] rdata;
    logic [7:0] flags;
    logic [7:0] enable;
  } bus_state_s;

  bus_state_s s_q, s_d;
  logic instr_tick;
  logic take;
  logic [7:0] impl_mask;
  logic [7:0] ev_bits;
  logic [7:0] rd_mux;
  chan_wr_s [NUM_TIMERS-1:0] chan_wr;
  chan_stat_s [NUM_TIMERS-1:0] chan_stat;

  // ----------------------------------------
  // instruction rate tick
  // ----------------------------------------
  instr_tick_gen u_tick (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .tick_o(instr_tick)
  );

  // ----------------------------------------
  // timer instances
  // ----------------------------------------
  // one timer per instance, count set by build [RULE12]
  generate
    for (genvar g = 0; g < NUM_TIMERS; g++) begin : g_chan
      localparam logic [7:0] BASE = 8'(g * CH_STRIDE);
      always_comb begin
        chan_wr[g].wdata = hwdata_i[7:0];
        chan_wr[g].wr_count = s_q.ph_valid && s_q.ph_write &&
                              s_q.ph_addr == BASE + OFS_COUNT; // [RULE1]
        chan_wr[g].wr_period = s_q.ph_valid && s_q.ph_write &&
                               s_q.ph_addr == BASE + OFS_PERIOD;
        chan_wr[g].wr_control = s_q.ph_valid && s_q.ph_write &&
                                s_q.ph_addr == BASE + OFS_CONTROL;
      end
      timer_channel u_chan (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .instr_tick_i(instr_tick),
        .wr_i(chan_wr[g]),
        .stat_o(chan_stat[g])
      );
      assign pwm_time_base_o[g] = chan_stat[g].match; // [RULE11]
    end
  endgenerate

  // ----------------------------------------
  // flag positions of the built timers
  // ----------------------------------------
  always_comb begin
    impl_mask = 8'h00;
    ev_bits = 8'h00;
    for (int i = 0; i < NUM_TIMERS; i++) begin
      impl_mask[FLAG_POS[i]] = 1'b1; // [RULE9] [RULE10]
      ev_bits[FLAG_POS[i]] = chan_stat[i].post_event; // [RULE9]
    end
  end

  // ----------------------------------------
  // read multiplexer on the data phase address
  // ----------------------------------------
  always_comb begin
    rd_mux = 8'h00;
    if (s_q.ph_addr == OFS_FLAGS) begin
      rd_mux = s_q.flags;
    end else if (s_q.ph_addr == OFS_ENABLE) begin
      rd_mux = s_q.enable;
    end else begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (s_q.ph_addr == 8'(i * CH_STRIDE) + OFS_COUNT) begin
          rd_mux = chan_stat[i].count; // [RULE1]
        end else if (s_q.ph_addr == 8'(i * CH_STRIDE) + OFS_PERIOD) begin
          rd_mux = chan_stat[i].period;
        end else if (s_q.ph_addr == 8'(i * CH_STRIDE) + OFS_CONTROL) begin
          rd_mux = chan_stat[i].control;
        end
      end
    end
  end

  // ----------------------------------------
  // bus phases, flags and enables
  // ----------------------------------------
  assign take = hsel_i && htrans_i[1] && hready_i;

  always_comb begin
    s_d = s_q;
    // address phase capture
    if (hready_i) begin
      s_d.ph_valid = take;
      s_d.ph_write = hwrite_i;
      s_d.ph_addr = haddr_i[ADDR_W-1:0];
    end
    // read: one wait cycle, data registered
    s_d.rd_wait = 1'b0;
    if (s_q.ph_valid && !s_q.ph_write && !s_q.rd_wait) begin
      s_d.rd_wait = 1'b1;
      s_d.rdata = {24'h00_0000, rd_mux};
      s_d.ph_valid = 1'b1;
      s_d.ph_write = 1'b0;
      s_d.ph_addr = s_q.ph_addr;
    end else if (s_q.rd_wait) begin
      s_d.ph_valid = take;
      s_d.ph_write = hwrite_i;
      s_d.ph_addr = haddr_i[ADDR_W-1:0];
    end
    // enable register write
    if (s_q.ph_valid && s_q.ph_write && s_q.ph_addr == OFS_ENABLE) begin
      s_d.enable = hwdata_i[7:0] & impl_mask; // [RULE10]
    end
    // write one to clear, then set wins
    if (s_q.ph_valid && s_q.ph_write && s_q.ph_addr == OFS_FLAGS) begin
      s_d.flags = s_q.flags & ~hwdata_i[7:0];
    end
    s_d.flags = (s_d.flags | ev_bits) & impl_mask; // [RULE4] [RULE9]
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '{flags: FLAGS_RST, enable: FLAGS_RST, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign hreadyout_o = !(s_q.ph_valid && !s_q.ph_write && !s_q.rd_wait);
  assign hresp_o = 1'b0;
  assign hrdata_o = s_q.rdata;
  assign irq_o = |(s_q.flags & s_q.enable); // [RULE10]

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_IRQ_LEVEL: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    irq_o == |(s_q.flags & s_q.enable)) // [RULE10]
    else $error("interrupt level disagrees with flags");
  AST_FLAG_SET: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    chan_stat[0].post_event |=> s_q.flags[FLAG_POS[0]]) // [RULE9]
    else $error("first timer flag not set");
  AST_FLAG_SET_LAST: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    chan_stat[NUM_TIMERS-1].post_event |=> s_q.flags[FLAG_POS[NUM_TIMERS-1]]) // [RULE9]
    else $error("last timer flag not set");
  AST_FLAG_ONLY_POST: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    $rose(s_q.flags[FLAG_POS[0]]) |-> $past(chan_stat[0].post_event)) // [RULE3]
    else $error("flag rose without a match event");
  AST_UNBUILT_ZERO: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (s_q.flags & ~impl_mask) == 8'h00 && (s_q.enable & ~impl_mask) == 8'h00) // [RULE12]
    else $error("flag or enable set at an unbuilt position");
  AST_READ_WAIT: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o) // [RULE1]
    else $error("read not answered after one wait");
  AST_COUNT_READBACK: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    s_q.rd_wait && s_q.ph_addr == OFS_COUNT |-> hrdata_o[7:0] == $past(chan_stat[0].count)) // [RULE1]
    else $error("count read back wrong");
  AST_OKAY: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    hresp_o == 1'b0 && hrdata_o[31:8] == 24'h00_0000) // [RULE1]
    else $error("bad response or upper read bits");

  CVR_IRQ: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i) $rose(irq_o));
  CVR_CLEAR: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    s_q.ph_valid && s_q.ph_write && s_q.ph_addr == OFS_FLAGS && |s_q.flags);
  CVR_MATCH: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    pwm_time_base_o[0] ##[1:64] pwm_time_base_o[0]);
endmodule
`default_nettype wire

// [tb/pwm_sink.sv]
// Purpose: stand-in for the pwm side, watching the time base pulses of one timer
// Assumes: each pulse lasts one clock
// Notes: gap is the clock count between the two latest pulses
`timescale 1ns/1ps
`default_nettype none
module pwm_sink #(
  parameter int unsigned N = 5
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic clr_i,
  input wire logic [2:0] sel_i,
  input wire logic [N-1:0] pulse_i,
  output logic [15:0] pulses_o,
  output logic [15:0] gap_o
);
  logic [15:0] run_q;
  // ----------------------------------------
  // pulse counting
  // ----------------------------------------
  // count pulses of the watched timer and time their spacing
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      run_q <= 16'h0000;
      pulses_o <= 16'h0000;
      gap_o <= 16'h0000;
    end else if (clr_i) begin
      run_q <= 16'h0000;
      pulses_o <= 16'h0000;
      gap_o <= 16'h0000;
    end else if (pulse_i[sel_i]) begin
      pulses_o <= pulses_o + 16'h0001;
      gap_o <= run_q + 16'h0001;
      run_q <= 16'h0000;
    end else begin
      run_q <= run_q + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// [tb/period_match_timer8_tb.sv]
// Purpose: self-checking bench of the period match timer group
// Assumes: bus reads take one wait state, writes none
// Notes: stimulus values come from a bench lfsr seeded with 41
`timescale 1ns/1ps
`default_nettype none
module period_match_timer8_tb;
  import period_timer_pkg::*;
  localparam int unsigned NT = MAX_TIMERS;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hready, hresp, irq, clr = 1'b0;
  logic [2:0] sel = 3'b000;
  logic [31:0] hrdata, rnd = 32'h0000_0029, v;
  logic [NT-1:0] pwm;
  logic [15:0] pulses, gap;
  int err_count = 0;
  int comparisons = 0;

  always #4 clk_sys_i = ~clk_sys_i;

  period_timer_top #(.NUM_TIMERS(NT)) dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp),
    .hrdata_o(hrdata), .irq_o(irq), .pwm_time_base_o(pwm));
  pwm_sink #(.N(NT)) far (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .clr_i(clr),
    .sel_i(sel), .pulse_i(pwm), .pulses_o(pulses), .gap_o(gap));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // lfsr step, seeded with 41
  function automatic logic [31:0] lfsr(input logic [31:0] r);
    return {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
  endfunction
  // next random word
  task automatic step_rnd();
    rnd = lfsr(rnd);
  endtask
  // expected clocks between matches
  function automatic logic [31:0] exp_gap(input logic [7:0] p, input logic [1:0] d);
    return (32'(p) + 1) * ((d == 2'b00) ? 1 : (d == 2'b01) ? 4 : 16) * INSTR_DIV;
  endfunction
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  // single word bus cycles; hready is judged settled before each edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0000_00, a};
    @(negedge clk_sys_i);
    while (hready !== 1'b1) @(negedge clk_sys_i);
    @(posedge clk_sys_i);
    htrans <= 2'b00;
    hwdata <= d;
    @(negedge clk_sys_i);
    while (hready !== 1'b1) @(negedge clk_sys_i);
    v = hrdata;
    chk("hresp", 32'h0000_0000, {31'h0, hresp});
    @(posedge clk_sys_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(name, exp, v);
  endtask
  task automatic restart_sink(input int i);
    sel <= 3'(i);
    clr <= 1'b1;
    @(posedge clk_sys_i);
    clr <= 1'b0;
  endtask
  task automatic close_out();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    logic [7:0] b, p, c;
    repeat (8) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    @(posedge clk_sys_i);
    // reset values of every timer
    for (int i = 0; i < NT; i++) begin
      b = 8'(CH_STRIDE * i);
      rdc("count_rst", b + OFS_COUNT, 32'(COUNT_RST));
      rdc("period_rst", b + OFS_PERIOD, 32'(PERIOD_RST));
      rdc("control_rst", b + OFS_CONTROL, 32'(CONTROL_RST));
    end
    rdc("flags_rst", OFS_FLAGS, 32'h0000_0000);
    rdc("enable_rst", OFS_ENABLE, 32'h0000_0000);
    // read back random values, control write keeps count
    for (int i = 0; i < NT; i++) begin
      b = 8'(CH_STRIDE * i);
      step_rnd();
      wr(b + OFS_PERIOD, rnd);
      rdc("period_rw", b + OFS_PERIOD, {24'h0, rnd[7:0]});
      wr(b + OFS_COUNT, ~rnd);
      c = {rnd[15:11], 1'b0, rnd[9:8]};
      wr(b + OFS_CONTROL, {24'h0, c});
      rdc("control_rw", b + OFS_CONTROL, {24'h0, c});
      rdc("count_kept", b + OFS_COUNT, {24'h0, ~rnd[7:0]});
    end
    wr(8'h7c, 32'h0000_00a5);
    rdc("unmapped", 8'h7c, 32'h0000_0000);
    rdc("unmapped_gap", 8'h0c, 32'h0000_0000);
    // stopped timer holds its count
    wr(OFS_CONTROL, 32'h0000_0000);
    wr(OFS_COUNT, 32'h0000_0010);
    repeat (100) @(posedge clk_sys_i);
    rdc("count_stopped", OFS_COUNT, 32'h0000_0010);
    // every prescale select, timers taken in turn
    for (int s = 0; s < 4; s++) begin
      b = 8'(CH_STRIDE * (s % NT));
      p = 8'(2 + s);
      wr(b + OFS_PERIOD, {24'h0, p});
      wr(b + OFS_COUNT, 32'h0000_0000);
      restart_sink(s % NT);
      wr(b + OFS_CONTROL, 32'(4 + s));
      for (int k = 0; k < 2000 && pulses < 3; k++) @(negedge clk_sys_i);
      chk("match_gap", exp_gap(p, 2'(s)), {16'h0, gap});
      wr(b + OFS_CONTROL, 32'h0000_0000);
    end
    // postscaler, flag position, mask and clear per timer
    for (int i = 0; i < NT; i++) begin
      b = 8'(CH_STRIDE * i);
      step_rnd();
      wr(b + OFS_PERIOD, 32'h0000_0003);
      wr(b + OFS_COUNT, 32'h0000_0000);
      wr(OFS_FLAGS, 32'h0000_00ff);
      wr(OFS_ENABLE, 32'(1 << FLAG_POS[i]));
      restart_sink(i);
      wr(b + OFS_CONTROL, 32'({rnd[3:0], 3'b100}));
      for (int k = 0; k < 3000 && irq !== 1'b1; k++) @(negedge clk_sys_i);
      chk("post_matches", 32'(rnd[3:0]) + 1, {16'h0, pulses});
      rdc("flag_pos", OFS_FLAGS, 32'(1 << FLAG_POS[i]));
      wr(OFS_ENABLE, 32'h0000_0000);
      @(negedge clk_sys_i);
      chk("irq_masked", 32'h0000_0000, {31'h0, irq});
      wr(b + OFS_CONTROL, 32'h0000_0000);
      wr(OFS_FLAGS, 32'h0000_00ff);
      rdc("flag_clear", OFS_FLAGS, 32'h0000_0000);
    end
    // reset in mid run
    wr(OFS_PERIOD, 32'h0000_00ff);
    wr(OFS_CONTROL, 32'h0000_0004);
    repeat (300) @(posedge clk_sys_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    @(posedge clk_sys_i);
    rdc("count_rerst", OFS_COUNT, 32'h0000_0000);
    rdc("control_rerst", OFS_CONTROL, 32'h0000_0000);
    close_out();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    err_count++;
    close_out();
  end
endmodule
`default_nettype wire
